// *** rtl/pgl_pkg.sv ***
// Package: register map, field layout, reset values and timing for the power-good / regulator bank
package pgl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PG_TREE_CTL_PIN_MASK_OFS  = 8'hac;
  localparam logic [7:0] LDO_A1_CONTROL_OFS        = 8'hae;
  localparam logic [7:0] POWER_GOOD_STATUS_ONE_OFS = 8'hb0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PG_TREE_CTL_PIN_MASK_RST  = 8'hff;
  localparam logic [7:0] LDO_A1_CONTROL_RST        = 8'h7d;
  localparam logic [7:0] POWER_GOOD_STATUS_ONE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Pin-mask field positions
  // ----------------------------------------------------------------
  localparam int OUT1_IN3_MASK_BIT = 7;
  localparam int OUT1_IN6_MASK_BIT = 6;
  localparam int OUT4_IN3_MASK_BIT = 5;
  localparam int OUT4_IN6_MASK_BIT = 4;
  localparam int OUT2_IN3_MASK_BIT = 3;
  localparam int OUT2_IN6_MASK_BIT = 2;
  localparam int OUT3_IN3_MASK_BIT = 1;
  localparam int OUT3_IN6_MASK_BIT = 0;

  // ----------------------------------------------------------------
  // Regulator control field positions
  // ----------------------------------------------------------------
  localparam int DISCHARGE_MSB     = 7;
  localparam int DISCHARGE_LSB     = 6;
  localparam int SHUTDOWN_CFG_BIT  = 5;
  localparam int VOLT_CODE_MSB     = 4;
  localparam int VOLT_CODE_LSB     = 1;
  localparam int ENABLE_BIT        = 0;

  // ----------------------------------------------------------------
  // Discharge codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DISCHARGE_NONE  = 2'h0;
  localparam logic [1:0] DISCHARGE_100R  = 2'h1;
  localparam logic [1:0] DISCHARGE_200R  = 2'h2;
  localparam logic [1:0] DISCHARGE_500R  = 2'h3;

  // ----------------------------------------------------------------
  // Emergency-shutdown off-time choices and clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ    = 250;
  localparam int ESD_1_MS   = 1;
  localparam int ESD_5_MS   = 5;
  localparam int ESD_10_MS  = 10;
  localparam int ESD_100_MS = 100;
  localparam logic [1:0] ESD_SEL_1MS   = 2'h0;
  localparam logic [1:0] ESD_SEL_5MS   = 2'h1;
  localparam logic [1:0] ESD_SEL_10MS  = 2'h2;
  localparam logic [1:0] ESD_SEL_100MS = 2'h3;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;

endpackage : pgl_pkg

// *** rtl/pgl_esd_timer.sv ***
// Timer that holds the regulator off for the selected emergency-shutdown time
`timescale 1ns/1ps
module pgl_esd_timer #(
  parameter int CYC_PER_MS = pgl_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic [1:0] i_sel,
  // Status
  output logic            o_busy
);

  localparam int CW = 32;

  logic [CW-1:0] count_q;

  // ----------------------------------------------------------------
  // Off-time lookup
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] off_cycles(input logic [1:0] sel);
    logic [CW-1:0] ms;
    ms = CW'(pgl_pkg::ESD_1_MS);
    unique case (sel)
      pgl_pkg::ESD_SEL_1MS:   ms = CW'(pgl_pkg::ESD_1_MS);
      pgl_pkg::ESD_SEL_5MS:   ms = CW'(pgl_pkg::ESD_5_MS);
      pgl_pkg::ESD_SEL_10MS:  ms = CW'(pgl_pkg::ESD_10_MS);
      pgl_pkg::ESD_SEL_100MS: ms = CW'(pgl_pkg::ESD_100_MS);
    endcase
    return CW'(ms * CW'(CYC_PER_MS));
  endfunction : off_cycles

  // ----------------------------------------------------------------
  // Countdown; a fresh event restarts the full time
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
    end else if (i_start) begin
      count_q <= off_cycles(i_sel);
    end else if (count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  assign o_busy = (count_q != '0);

endmodule : pgl_esd_timer

// *** rtl/pgl_regs.sv ***
// Power-good mask, regulator control and power-good status register bank
// What this block does
// RULE1 - Mask bits 7,6 drop control inputs three,six from output one tree when set.
// RULE2 - Mask bits 5,4 drop control inputs three,six from output four tree when set.
// RULE3 - Mask bits 3,2 drop control inputs three,six from output two tree when set.
// RULE4 - Mask bits 1,0 drop control inputs three,six from output three tree when set.
// RULE5 - Pin-mask register resets to all ones, excluding both inputs everywhere.
// RULE6 - Discharge field bits 7:6 picks none,100,200,500 ohms; resets to code 1.
// RULE7 - Shutdown-config clear: emergency shutdown holds regulator off for factory time.
// RULE8 - Shutdown-config bit 5 set: only enable bit controls regulator; resets to one.
// RULE9 - Voltage code bits 4:1 selects output voltage; resets to E hex.
// RULE10 - Bit 0 enables the regulator; resets to one.
// RULE11 - Regulator control register resets to 7D hex.
// RULE12 - Status bits read one while rail in regulation; read-only, reset zero.
// RULE13 - Status order bit 7..0: ldo two, switch a one, step-down six..one.
// RULE14 - Host writes to the status register are ignored.
// RULE15 - Each output asserts only while all unmasked tree members are good.
`timescale 1ns/1ps
module pgl_regs #(
  parameter int         CYC_PER_MS = pgl_pkg::CYC_PER_MS,
  parameter logic [1:0] ESD_SEL    = pgl_pkg::ESD_SEL_1MS
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Register access port from the serial engine
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_hit,
  // Control pins
  input  wire logic       i_control_input_three,
  input  wire logic       i_control_input_six,
  // Rest of each power-good tree (other members, already masked)
  input  wire logic       i_tree_one_good,
  input  wire logic       i_tree_two_good,
  input  wire logic       i_tree_three_good,
  input  wire logic       i_tree_four_good,
  // Rail power-good indications
  input  wire logic       i_ldo_two_good_flag,
  input  wire logic       i_switch_a_one_good_flag,
  input  wire logic       i_step_down_six_good_flag,
  input  wire logic       i_step_down_five_good_flag,
  input  wire logic       i_step_down_four_good_flag,
  input  wire logic       i_step_down_three_good_flag,
  input  wire logic       i_step_down_two_good_flag,
  input  wire logic       i_step_down_one_good_flag,
  // Emergency shutdown event
  input  wire logic       i_emergency_shutdown,
  // Power-good outputs
  output logic            o_pg_output_one,
  output logic            o_pg_output_two,
  output logic            o_pg_output_three,
  output logic            o_pg_output_four,
  // Regulator controls
  output logic            o_reg_enable,
  output logic [1:0]      o_reg_discharge_select,
  output logic [3:0]      o_reg_voltage_code
);

  logic [7:0] pin_mask_q;
  logic [7:0] ldo_ctl_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic       esd_busy;
  logic       esd_start;
  logic       pg1_d;
  logic       pg2_d;
  logic       pg3_d;
  logic       pg4_d;

  // ----------------------------------------------------------------
  // Tree evaluation helper
  // ----------------------------------------------------------------
  // A masked member counts as good, so it cannot hold the output low
  function automatic logic tree_good(input logic rest, input logic in3, input logic in6,
                                     input logic m3, input logic m6);
    return rest & (in3 | m3) & (in6 | m6);
  endfunction : tree_good

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    return wr & (a == ofs);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Pin-mask register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_mask_q <= pgl_pkg::PG_TREE_CTL_PIN_MASK_RST; // see RULE5
    end else if (wr_hit(i_reg_wr, i_reg_addr, pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS)) begin
      pin_mask_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Regulator control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ldo_ctl_q <= pgl_pkg::LDO_A1_CONTROL_RST; // see RULE11
    end else if (wr_hit(i_reg_wr, i_reg_addr, pgl_pkg::LDO_A1_CONTROL_OFS)) begin
      ldo_ctl_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Status snapshot, refreshed every clock; host writes have no path here
  // ----------------------------------------------------------------
  always_comb begin
    status_d = {i_ldo_two_good_flag, i_switch_a_one_good_flag,
                i_step_down_six_good_flag, i_step_down_five_good_flag,
                i_step_down_four_good_flag, i_step_down_three_good_flag,
                i_step_down_two_good_flag, i_step_down_one_good_flag}; // see RULE13
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= pgl_pkg::POWER_GOOD_STATUS_ONE_RST; // see RULE12
    end else begin
      status_q <= status_d; // see RULE14
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    o_reg_hit = 1'b1;
    unique case (i_reg_addr)
      pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS:  o_reg_rdata = pin_mask_q;
      pgl_pkg::LDO_A1_CONTROL_OFS:        o_reg_rdata = ldo_ctl_q;
      pgl_pkg::POWER_GOOD_STATUS_ONE_OFS: o_reg_rdata = status_q; // see RULE12
      default: begin
        o_reg_rdata = 8'h00;
        o_reg_hit   = 1'b0;
      end
    endcase
    if (!i_reg_rd) begin
      o_reg_rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Power-good trees
  // ----------------------------------------------------------------
  always_comb begin
    pg1_d = tree_good(i_tree_one_good, i_control_input_three, i_control_input_six,
                      pin_mask_q[pgl_pkg::OUT1_IN3_MASK_BIT],
                      pin_mask_q[pgl_pkg::OUT1_IN6_MASK_BIT]); // see RULE1 see RULE15
    pg4_d = tree_good(i_tree_four_good, i_control_input_three, i_control_input_six,
                      pin_mask_q[pgl_pkg::OUT4_IN3_MASK_BIT],
                      pin_mask_q[pgl_pkg::OUT4_IN6_MASK_BIT]); // see RULE2 see RULE15
    pg2_d = tree_good(i_tree_two_good, i_control_input_three, i_control_input_six,
                      pin_mask_q[pgl_pkg::OUT2_IN3_MASK_BIT],
                      pin_mask_q[pgl_pkg::OUT2_IN6_MASK_BIT]); // see RULE3 see RULE15
    pg3_d = tree_good(i_tree_three_good, i_control_input_three, i_control_input_six,
                      pin_mask_q[pgl_pkg::OUT3_IN3_MASK_BIT],
                      pin_mask_q[pgl_pkg::OUT3_IN6_MASK_BIT]); // see RULE4 see RULE15
  end

  // Registered so the pins never glitch while masks and inputs change together
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pg_output_one   <= 1'b0;
      o_pg_output_two   <= 1'b0;
      o_pg_output_three <= 1'b0;
      o_pg_output_four  <= 1'b0;
    end else begin
      o_pg_output_one   <= pg1_d;
      o_pg_output_two   <= pg2_d;
      o_pg_output_three <= pg3_d;
      o_pg_output_four  <= pg4_d;
    end
  end

  // ----------------------------------------------------------------
  // Emergency shutdown hold-off
  // ----------------------------------------------------------------
  assign esd_start = i_emergency_shutdown & ~ldo_ctl_q[pgl_pkg::SHUTDOWN_CFG_BIT]; // see RULE7

  pgl_esd_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_esd_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (esd_start),
    .i_sel   (ESD_SEL),
    .o_busy  (esd_busy)
  );

  // ----------------------------------------------------------------
  // Regulator outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_enable           <= 1'b0;
      o_reg_discharge_select <= pgl_pkg::DISCHARGE_100R;
      o_reg_voltage_code     <= pgl_pkg::LDO_A1_CONTROL_RST[pgl_pkg::VOLT_CODE_MSB:pgl_pkg::VOLT_CODE_LSB];
    end else begin
      // Config bit set leaves only the enable bit in charge
      o_reg_enable <= ldo_ctl_q[pgl_pkg::ENABLE_BIT] &
                      (ldo_ctl_q[pgl_pkg::SHUTDOWN_CFG_BIT] | ~(esd_busy | esd_start)); // see RULE8 see RULE10
      o_reg_discharge_select <= ldo_ctl_q[pgl_pkg::DISCHARGE_MSB:pgl_pkg::DISCHARGE_LSB]; // see RULE6
      o_reg_voltage_code     <= ldo_ctl_q[pgl_pkg::VOLT_CODE_MSB:pgl_pkg::VOLT_CODE_LSB]; // see RULE9
    end
  end

endmodule : pgl_regs

// *** bench/pgl_regs_monitor.sv ***
// Checker for the power-good and regulator register bank
`timescale 1ns/1ps
module pgl_regs_monitor (
  // Clock, reset and register port
  input wire logic       i_mclk, i_rst_n, i_reg_wr, i_reg_rd,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  // Pins, trees and rails
  input wire logic       i_control_input_three, i_control_input_six, i_emergency_shutdown,
  input wire logic       i_tree_one_good, i_tree_two_good, i_tree_three_good, i_tree_four_good,
  input wire logic       i_ldo_two_good_flag, i_switch_a_one_good_flag, i_step_down_six_good_flag,
  input wire logic       i_step_down_five_good_flag, i_step_down_four_good_flag,
  input wire logic       i_step_down_three_good_flag, i_step_down_two_good_flag, i_step_down_one_good_flag,
  // Outputs
  input wire logic       o_pg_output_one, o_pg_output_two, o_pg_output_three, o_pg_output_four,
  input wire logic       o_reg_enable,
  input wire logic [1:0] o_reg_discharge_select,
  input wire logic [3:0] o_reg_voltage_code
);
  logic [7:0] msk_q, ctl_q;
  logic       c3, c6;
  assign c3 = i_control_input_three;
  assign c6 = i_control_input_six;
  // Shadow copies of the writable registers, kept from the write strobes alone
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) msk_q <= pgl_pkg::PG_TREE_CTL_PIN_MASK_RST;
    else if (i_reg_wr && i_reg_addr == pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS) msk_q <= i_reg_wdata;
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) ctl_q <= pgl_pkg::LDO_A1_CONTROL_RST;
    else if (i_reg_wr && i_reg_addr == pgl_pkg::LDO_A1_CONTROL_OFS) ctl_q <= i_reg_wdata;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_esd; i_emergency_shutdown && !ctl_q[5]; endsequence
  sequence s_off; (!o_reg_enable) [*8]; endsequence
  // Outputs still hold their reset value at the releasing edge, so checking starts one edge later
  property p_pg_one; i_rst_n |=>
    o_pg_output_one == $past(i_tree_one_good && (msk_q[7] || c3) && (msk_q[6] || c6));
  endproperty
  a_pg_one: assert property (p_pg_one) else $error("output one mismatch");
  property p_pg_four; i_rst_n |=>
    o_pg_output_four == $past(i_tree_four_good && (msk_q[5] || c3) && (msk_q[4] || c6));
  endproperty
  a_pg_four: assert property (p_pg_four) else $error("output four mismatch");
  property p_pg_two; i_rst_n |=>
    o_pg_output_two == $past(i_tree_two_good && (msk_q[3] || c3) && (msk_q[2] || c6));
  endproperty
  a_pg_two: assert property (p_pg_two) else $error("output two mismatch");
  property p_pg_three; i_rst_n |=>
    o_pg_output_three == $past(i_tree_three_good && (msk_q[1] || c3) && (msk_q[0] || c6));
  endproperty
  a_pg_three: assert property (p_pg_three) else $error("output three mismatch");
  property p_status; $past(i_rst_n) && i_reg_rd && i_reg_addr == pgl_pkg::POWER_GOOD_STATUS_ONE_OFS |->
    o_reg_rdata == $past({i_ldo_two_good_flag, i_switch_a_one_good_flag, i_step_down_six_good_flag,
    i_step_down_five_good_flag, i_step_down_four_good_flag, i_step_down_three_good_flag,
    i_step_down_two_good_flag, i_step_down_one_good_flag}); endproperty
  a_status: assert property (p_status) else $error("status mismatch");
  property p_mask_rd; i_reg_rd && i_reg_addr == pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS |-> o_reg_rdata == msk_q;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback mismatch");
  property p_ctl_rd; i_reg_rd && i_reg_addr == pgl_pkg::LDO_A1_CONTROL_OFS |-> o_reg_rdata == ctl_q; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control readback mismatch");
  property p_fields; i_rst_n |=> {o_reg_discharge_select, o_reg_voltage_code} == $past({ctl_q[7:6], ctl_q[4:1]});
  endproperty
  a_fields: assert property (p_fields) else $error("field outputs mismatch");
  property p_esd; s_esd |=> s_off; endproperty
  a_esd: assert property (p_esd) else $error("regulator not held off");
  property p_follow; ctl_q[5] [*2] |=> o_reg_enable == $past(ctl_q[0]); endproperty
  a_follow: assert property (p_follow) else $error("enable not following bit");
  property p_disable; !ctl_q[0] |=> !o_reg_enable; endproperty
  a_disable: assert property (p_disable) else $error("regulator on while disabled");
endmodule : pgl_regs_monitor

// *** bench/pgl_host_model.sv ***
// Register-port driver standing in for the serial host engine
`timescale 1ns/1ps
module pgl_host_model (
  input  wire logic i_mclk,
  output logic       o_wr,
  output logic       o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  // Released lines show the inverse so a stale value is never mistaken for a live one
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    {o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d};
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_mclk);
    {o_rd, o_addr} <= {1'b1, a};
    @(posedge i_mclk);
    {o_rd, o_addr} <= {1'b0, ~a};
  endtask : rd_reg
endmodule : pgl_host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the power-good and regulator register bank
`timescale 1ns/1ps
module tb_top;
  logic       i_mclk, i_rst_n, wr, rd, in3, in6, esd, hit, en;
  logic [7:0] addr, wdata, rdata, rails, m, c, r;
  logic [3:0] tree, pg, code;
  logic [1:0] disc;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  int         miscompares, n_checks, k;
  initial i_mclk = 1'b0;
  always #2 i_mclk = ~i_mclk;
  pgl_host_model u_host (.i_mclk(i_mclk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  pgl_regs #(.CYC_PER_MS(10), .ESD_SEL(pgl_pkg::ESD_SEL_1MS)) u_pgl_regs (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_hit(hit), .i_control_input_three(in3), .i_control_input_six(in6),
    .i_tree_one_good(tree[0]), .i_tree_two_good(tree[1]), .i_tree_three_good(tree[2]), .i_tree_four_good(tree[3]),
    .i_ldo_two_good_flag(rails[7]), .i_switch_a_one_good_flag(rails[6]), .i_step_down_six_good_flag(rails[5]),
    .i_step_down_five_good_flag(rails[4]), .i_step_down_four_good_flag(rails[3]),
    .i_step_down_three_good_flag(rails[2]), .i_step_down_two_good_flag(rails[1]),
    .i_step_down_one_good_flag(rails[0]), .i_emergency_shutdown(esd), .o_pg_output_one(pg[0]),
    .o_pg_output_two(pg[1]), .o_pg_output_three(pg[2]), .o_pg_output_four(pg[3]), .o_reg_enable(en),
    .o_reg_discharge_select(disc), .o_reg_voltage_code(code));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Each note carries the expected mapped flag above the expected read byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({(a == pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS) || (a == pgl_pkg::LDO_A1_CONTROL_OFS) ||
                     (a == pgl_pkg::POWER_GOOD_STATUS_ONE_OFS), e});
    u_host.rd_reg(a);
  endtask : rd_chk
  // Masked members count as good; tree vector runs four, three, two, one
  function automatic logic [3:0] pg_exp(input logic [7:0] v);
    pg_exp = tree & {(v[5] | in3) & (v[4] | in6), (v[1] | in3) & (v[0] | in6),
                     (v[3] | in3) & (v[2] | in6), (v[7] | in3) & (v[6] | in6)};
  endfunction : pg_exp
  always @(posedge i_mclk) begin
    if (rd) begin
      note = exp_q.pop_front();
      check("readback", rdata, note[7:0]);
      check("hit", {7'h0, hit}, {7'h0, note[8]});
    end
  end
  initial begin
    void'($urandom(32'h9ce1));
    {i_rst_n, in3, in6, esd, rails, tree} = {4'h0, 8'h00, 4'hf};
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_chk(pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS, 8'hff);
    rd_chk(pgl_pkg::LDO_A1_CONTROL_OFS, 8'h7d);
    rd_chk(pgl_pkg::POWER_GOOD_STATUS_ONE_OFS, 8'h00);
    #1 check("pg_reset", {4'h0, pg}, 8'h0f);
    rd_chk(8'had, 8'h00);
    repeat (4) begin
      r = 8'($urandom);
      rails <= r;
      u_host.wr_reg(pgl_pkg::POWER_GOOD_STATUS_ONE_OFS, ~r);
      rd_chk(pgl_pkg::POWER_GOOD_STATUS_ONE_OFS, r);
    end
    repeat (16) begin
      m = 8'($urandom);
      u_host.wr_reg(pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS, m);
      {in3, in6, tree} <= 6'($urandom);
      rd_chk(pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS, m);
      #1 check("pg", {4'h0, pg}, {4'h0, pg_exp(m)});
    end
    for (int d = 0; d < 4; d++) begin
      c = {2'(d), 1'b1, 4'($urandom), 1'(d)};
      u_host.wr_reg(pgl_pkg::LDO_A1_CONTROL_OFS, c);
      rd_chk(pgl_pkg::LDO_A1_CONTROL_OFS, c);
      #1 check("ctl_out", {disc, code, 1'b0, en}, {c[7:6], c[4:1], 1'b0, c[0]});
    end
    u_host.wr_reg(pgl_pkg::LDO_A1_CONTROL_OFS, 8'h5d);
    esd <= 1'b1;
    @(posedge i_mclk);
    esd <= 1'b0;
    #1;
    for (k = 0; k < 40 && en !== 1'b1; k++) begin
      @(posedge i_mclk);
      #1;
    end
    check("esd_off", 8'(k >= 10 && k < 40), 8'h01);
    if (k == 40) stop_test();
    u_host.wr_reg(pgl_pkg::LDO_A1_CONTROL_OFS, 8'h7d);
    esd <= 1'b1;
    repeat (3) @(posedge i_mclk);
    esd <= 1'b0;
    #1 check("esd_ignored", {7'h0, en}, 8'h01);
    i_rst_n <= 1'b0;
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_chk(pgl_pkg::PG_TREE_CTL_PIN_MASK_OFS, 8'hff);
    stop_test();
  end
endmodule : tb_top
bind pgl_regs pgl_regs_monitor u_pgl_regs_monitor (.*);
